// >>> shared/link_ctrl_defines.svh
// register indices, reset values and field positions of the link control bank
`ifndef LINK_CTRL_DEFINES_SVH
`define LINK_CTRL_DEFINES_SVH

// register indices; byte address is four times the index
`define IDX_TS_LSB       10'h160
`define IDX_LINK_EN      10'h200
`define IDX_MODE         10'h201
`define IDX_KM1          10'h202
`define IDX_AUX          10'h210
`define IDX_STATUS       10'h211

// reset values
`define RST_TS_LSB       1'b0
`define RST_LINK_EN      1'b1
`define RST_MODE         6'h00
`define RST_KM1          8'h1F
`define RST_CAL_EN       1'b0
`define RST_TS_RECV      1'b0

// field positions
`define BIT_TS_EN        0
`define BIT_LINK_EN      0
`define MODE_MSB         5
`define KM1_MSB          7
`define BIT_CAL_EN       0
`define BIT_TS_RECV      1
`define BIT_STAT_RUN     0
`define BIT_STAT_64B     1
`define STAT_K_LSB       8
`define STAT_K_MSB       17
`define BIT_SAMPLE_CTRL  0

// link constants
`define K_64B_NUM        16'h0100
`define ILA_CS_VALUE     2'h0

`endif

// >>> shared/link_ctrl_pkg.sv
// types shared by the link control bank and its mode decoder
package link_ctrl_pkg;

	typedef logic [5:0] mode_t;
	typedef logic [7:0] km1_t;
	typedef logic [9:0] kcount_t;

	typedef enum logic [0:0]
	{
		LINK_HELD = 1'b0,
		LINK_RUN  = 1'b1
	} link_state_e;

endpackage : link_ctrl_pkg

// >>> shared/mode_cfg_if.sv
// mode and multiframe settings passed to the mode decoder and back
`timescale 1ns/1ps
interface mode_cfg_if;
	link_ctrl_pkg::mode_t   mode;
	link_ctrl_pkg::km1_t    km1;
	logic                   is_64b;
	link_ctrl_pkg::kcount_t k_eff_m1;

	modport ctrl
	(
		output mode,
		output km1,
		input  is_64b,
		input  k_eff_m1
	);

	modport decode
	(
		input  mode,
		input  km1,
		output is_64b,
		output k_eff_m1
	);
endinterface : mode_cfg_if

// >>> src/mode_decode.sv
// decodes output mode into link layer and effective frames per multiframe minus one
`timescale 1ns/1ps
`include "link_ctrl_defines.svh"
module mode_decode #(
	parameter link_ctrl_pkg::mode_t FIRST_64B_MODE = 6'h20,
	parameter int                   E_64B          = 1,
	parameter int                   F_64B          = 8
) (
	mode_cfg_if.decode cfg
);

	logic [15:0] k_64b;

	always_comb
	begin
		k_64b      = 16'(`K_64B_NUM * 16'(E_64B) / 16'(F_64B));
		cfg.is_64b = (cfg.mode >= FIRST_64B_MODE);
		if (cfg.is_64b)
			cfg.k_eff_m1 = 10'(k_64b - 16'h0001);
		else
			cfg.k_eff_m1 = {2'h0, cfg.km1};
	end

endmodule : mode_decode

// >>> src/serial_link_control_regs.sv
// link control register bank with sample formatting and multiframe counter
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps
`include "link_ctrl_defines.svh"
module serial_link_control_regs #(
	parameter int                   CHANNELS       = 4,
	parameter int                   RES            = 12,
	parameter int                   N_BITS         = 16,
	parameter link_ctrl_pkg::mode_t FIRST_64B_MODE = 6'h20,
	parameter int                   E_64B          = 1,
	parameter int                   F_64B          = 8
) (
	// clock and reset
	input  wire logic                       CORE_CLK_I,
	input  wire logic                       RST_N_I,
	// wishbone slave
	input  wire logic                       CYC_I,
	input  wire logic                       STB_I,
	input  wire logic                       WE_I,
	input  wire logic [11:0]                ADR_I,
	input  wire logic [3:0]                 SEL_I,
	input  wire logic [31:0]                DAT_I,
	output logic      [31:0]                DAT_O,
	output logic                            ACK_O,
	// converter samples and pins
	input  wire logic [CHANNELS*RES-1:0]    ADC_SAMPLE_I,
	input  wire logic                       TIMESTAMP_I,
	input  wire logic                       SYSREF_I,
	// transport output
	output logic      [CHANNELS*N_BITS-1:0] SAMPLE_O,
	output logic      [1:0]                 ILA_CS_O,
	output logic                            MF_BOUNDARY_O,
	// link control
	output logic                            LINK_RESET_N_O,
	output logic                            SERDES_POWER_DOWN_O,
	output logic                            LINK_CLK_ENABLE_O,
	output logic                            LINK_IS_64B_O,
	output logic      [5:0]                 LINK_OUTPUT_MODE_O,
	output logic                            CAL_ENABLE_O,
	output logic                            TS_RECV_ENABLE_O
);

	////////////////////////////////////////////////////////////////////////
	// declarations

	mode_cfg_if cfg ();

	logic                       ack;
	logic                       next_ack;
	logic [31:0]                rdata;
	logic [31:0]                next_rdata;
	logic [9:0]                 index;
	logic                       wr_lane0;

	logic                       timestamp_insert_enable;
	logic                       next_timestamp_insert_enable;
	logic                       link_subsystem_enable;
	logic                       next_link_subsystem_enable;
	link_ctrl_pkg::mode_t       link_output_mode;
	link_ctrl_pkg::mode_t       next_link_output_mode;
	link_ctrl_pkg::km1_t        multiframe_length_minus_one;
	link_ctrl_pkg::km1_t        next_multiframe_length_minus_one;
	logic                       cal_enable;
	logic                       next_cal_enable;
	logic                       timestamp_receiver_enable;
	logic                       next_timestamp_receiver_enable;

	link_ctrl_pkg::link_state_e state;
	link_ctrl_pkg::link_state_e next_state;
	link_ctrl_pkg::kcount_t     mf_count;
	link_ctrl_pkg::kcount_t     next_mf_count;
	logic                       boundary;
	logic                       next_boundary;
	logic                       link_rst_n;
	logic                       next_link_rst_n;
	logic                       serdes_pd;
	logic                       next_serdes_pd;
	logic                       clk_en;
	logic                       next_clk_en;
	logic                       is_64b_q;
	logic                       next_is_64b_q;

	logic                       sysref_meta;
	logic                       sysref_sync;
	logic                       sysref_prev;
	logic                       sysref_rise;
	logic                       ts_meta;
	logic                       ts_sync;
	logic                       ts_bit;

	////////////////////////////////////////////////////////////////////////
	// mode decoder

	assign cfg.mode = link_output_mode;
	assign cfg.km1  = multiframe_length_minus_one;

	mode_decode #(
		.FIRST_64B_MODE (FIRST_64B_MODE),
		.E_64B          (E_64B),
		.F_64B          (F_64B)
	) u_mode_decode (
		.cfg (cfg.decode)
	);

	////////////////////////////////////////////////////////////////////////
	// wishbone slave: ack one cycle after request, writes land at ack edge

	assign index    = ADR_I[11:2];
	assign wr_lane0 = CYC_I && STB_I && WE_I && ack && SEL_I[0];

	always_comb
	begin
		next_ack   = CYC_I && STB_I && !ack;
		next_rdata = 32'h0000_0000;
		// unmapped addresses still ack and read zero
		case (index)
			`IDX_TS_LSB:
				next_rdata[`BIT_TS_EN] = timestamp_insert_enable;
			`IDX_LINK_EN:
				next_rdata[`BIT_LINK_EN] = link_subsystem_enable;
			`IDX_MODE:
				next_rdata[`MODE_MSB:0] = link_output_mode;
			`IDX_KM1:
				next_rdata[`KM1_MSB:0] = multiframe_length_minus_one;
			`IDX_AUX:
			begin
				next_rdata[`BIT_CAL_EN]  = cal_enable;
				next_rdata[`BIT_TS_RECV] = timestamp_receiver_enable;
			end
			`IDX_STATUS:
			begin
				next_rdata[`BIT_STAT_RUN] = (state == link_ctrl_pkg::LINK_RUN);
				next_rdata[`BIT_STAT_64B] = is_64b_q;
				next_rdata[`STAT_K_MSB:`STAT_K_LSB] = cfg.k_eff_m1;
			end
			default:
				next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			ack   <= 1'b0;
			rdata <= 32'h0000_0000;
		end
		else
		begin
			ack   <= next_ack;
			rdata <= next_rdata;
		end
	end

	assign ACK_O = ack;
	assign DAT_O = rdata;

	////////////////////////////////////////////////////////////////////////
	// register file; reserved bits are not stored and read zero

	always_comb
	begin
		next_timestamp_insert_enable     = timestamp_insert_enable;
		next_link_subsystem_enable       = link_subsystem_enable;
		next_link_output_mode            = link_output_mode;
		next_multiframe_length_minus_one = multiframe_length_minus_one;
		next_cal_enable                  = cal_enable;
		next_timestamp_receiver_enable   = timestamp_receiver_enable;
		// writes are not interlocked; ordering is the host's duty
		if (wr_lane0)
		begin
			case (index)
				`IDX_TS_LSB:
					next_timestamp_insert_enable = DAT_I[`BIT_TS_EN];
				`IDX_LINK_EN:
					next_link_subsystem_enable = DAT_I[`BIT_LINK_EN];
				`IDX_MODE:
					next_link_output_mode = DAT_I[`MODE_MSB:0];
				`IDX_KM1:
					next_multiframe_length_minus_one = DAT_I[`KM1_MSB:0];
				`IDX_AUX:
				begin
					next_cal_enable                = DAT_I[`BIT_CAL_EN];
					next_timestamp_receiver_enable = DAT_I[`BIT_TS_RECV];
				end
				default:
					next_cal_enable = cal_enable;
			endcase
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			timestamp_insert_enable     <= `RST_TS_LSB;
			link_subsystem_enable       <= `RST_LINK_EN;
			link_output_mode            <= `RST_MODE;
			multiframe_length_minus_one <= `RST_KM1;
			cal_enable                  <= `RST_CAL_EN;
			timestamp_receiver_enable   <= `RST_TS_RECV;
		end
		else
		begin
			timestamp_insert_enable     <= next_timestamp_insert_enable;
			link_subsystem_enable       <= next_link_subsystem_enable;
			link_output_mode            <= next_link_output_mode;
			multiframe_length_minus_one <= next_multiframe_length_minus_one;
			cal_enable                  <= next_cal_enable;
			timestamp_receiver_enable   <= next_timestamp_receiver_enable;
		end
	end

	assign LINK_OUTPUT_MODE_O = link_output_mode;
	assign CAL_ENABLE_O       = cal_enable;
	assign TS_RECV_ENABLE_O   = timestamp_receiver_enable;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			sysref_meta <= 1'b0;
			sysref_sync <= 1'b0;
			sysref_prev <= 1'b0;
			ts_meta     <= 1'b0;
			ts_sync     <= 1'b0;
		end
		else
		begin
			sysref_meta <= SYSREF_I;
			sysref_sync <= sysref_meta;
			sysref_prev <= sysref_sync;
			ts_meta     <= TIMESTAMP_I;
			ts_sync     <= ts_meta;
		end
	end

	assign sysref_rise = sysref_sync && !sysref_prev;

	////////////////////////////////////////////////////////////////////////
	// link state and multiframe counter

	always_comb
	begin
		next_state    = link_subsystem_enable ? link_ctrl_pkg::LINK_RUN
		                                      : link_ctrl_pkg::LINK_HELD;
		next_mf_count = mf_count;
		next_boundary = 1'b0;
		next_link_rst_n = link_subsystem_enable;
		next_serdes_pd  = !link_subsystem_enable;
		next_clk_en     = link_subsystem_enable;
		next_is_64b_q   = cfg.is_64b;
		case (state)
			link_ctrl_pkg::LINK_HELD:
				next_mf_count = '0;
			link_ctrl_pkg::LINK_RUN:
			begin
				if (sysref_rise || mf_count >= cfg.k_eff_m1)
				begin
					next_mf_count = '0;
					next_boundary = 1'b1;
				end
				else
					next_mf_count = mf_count + 10'h001;
			end
			default:
				next_mf_count = '0;
		endcase
		// no pulse on the edge where the link is switched off
		if (!link_subsystem_enable)
		begin
			next_mf_count = '0;
			next_boundary = 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			state      <= link_ctrl_pkg::LINK_HELD;
			mf_count   <= '0;
			boundary   <= 1'b0;
			link_rst_n <= 1'b0;
			serdes_pd  <= 1'b1;
			clk_en     <= 1'b0;
			is_64b_q   <= 1'b0;
		end
		else
		begin
			state      <= next_state;
			mf_count   <= next_mf_count;
			boundary   <= next_boundary;
			link_rst_n <= next_link_rst_n;
			serdes_pd  <= next_serdes_pd;
			clk_en     <= next_clk_en;
			is_64b_q   <= next_is_64b_q;
		end
	end

	assign MF_BOUNDARY_O       = boundary;
	assign LINK_RESET_N_O      = link_rst_n;
	assign SERDES_POWER_DOWN_O = serdes_pd;
	assign LINK_CLK_ENABLE_O   = clk_en;
	assign LINK_IS_64B_O       = is_64b_q;
	// alignment sequence never advertises the bit
	assign ILA_CS_O            = `ILA_CS_VALUE;

	////////////////////////////////////////////////////////////////////////
	// sample formatting

	always_comb
	begin
		// timestamp gated by insert enable
		// no extra stage: synchroniser already equals sample delay
		ts_bit = timestamp_insert_enable && ts_sync;
	end

	generate
		for (genvar ch = 0; ch < CHANNELS; ch++)
		begin : g_chan
			logic [RES-1:0]        smp_d1;
			logic [RES-1:0]        smp_d2;
			logic [N_BITS-1:0]     smp_out;
			logic [N_BITS-1:0]     next_smp_out;
			logic [N_BITS+RES-1:0] wide;

			always_comb
			begin
				// converter data left aligned in the N-bit field
				wide         = {smp_d2, {N_BITS{1'b0}}};
				next_smp_out = wide[N_BITS+RES-1 -: N_BITS];
				if (timestamp_insert_enable)
					next_smp_out[`BIT_SAMPLE_CTRL] = ts_bit;
				// zero from the edge the link clocks stop
				if (!link_subsystem_enable)
					next_smp_out = '0;
			end

			// two delays match the pin synchroniser
			always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
			begin
				if (!RST_N_I)
				begin
					smp_d1  <= '0;
					smp_d2  <= '0;
					smp_out <= '0;
				end
				else
				begin
					smp_d1  <= ADC_SAMPLE_I[ch*RES +: RES];
					smp_d2  <= smp_d1;
					smp_out <= next_smp_out;
				end
			end

			assign SAMPLE_O[ch*N_BITS +: N_BITS] = smp_out;
		end
	endgenerate

endmodule : serial_link_control_regs

// >>> verification/link_rx_model.sv
// receiver-side model measuring multiframe period and boundary count
`timescale 1ns/1ps
module link_rx_model (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	// link side
	input  wire logic        clk_en_i,
	input  wire logic        boundary_i,
	// observations
	output logic      [15:0] period_o,
	output logic      [15:0] pulses_o
);
	logic [15:0] cnt;
	logic [15:0] next_cnt;
	logic [15:0] next_period;
	logic [15:0] next_pulses;

	////////////////////////////////////////////////////////////////////////
	// frames per multiframe
	always_comb
	begin
		next_cnt    = cnt + 16'h0001;
		next_period = period_o;
		next_pulses = pulses_o;
		// gated link clock: receiver sees no frames
		if (!clk_en_i)
			next_cnt = 16'h0000;
		if (boundary_i)
		begin
			next_period = cnt + 16'h0001;
			next_pulses = pulses_o + 16'h0001;
			next_cnt    = 16'h0000;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
		if (!rst_n_i)
		begin
			cnt      <= 16'h0000;
			period_o <= 16'h0000;
			pulses_o <= 16'h0000;
		end
		else
		begin
			cnt      <= next_cnt;
			period_o <= next_period;
			pulses_o <= next_pulses;
		end
endmodule : link_rx_model

// >>> verification/link_ctrl_chk.sv
// port-level assertions for the link control bank
`timescale 1ns/1ps
module link_ctrl_chk #(
	parameter int                   CHANNELS       = 4,
	parameter int                   RES            = 12,
	parameter int                   N_BITS         = 16,
	parameter link_ctrl_pkg::mode_t FIRST_64B_MODE = 6'h20
) (
	// clock, reset and bus
	input wire logic                       CORE_CLK_I,
	input wire logic                       RST_N_I,
	input wire logic                       CYC_I,
	input wire logic                       STB_I,
	input wire logic                       ACK_O,
	// sample path
	input wire logic [CHANNELS*RES-1:0]    ADC_SAMPLE_I,
	input wire logic [CHANNELS*N_BITS-1:0] SAMPLE_O,
	input wire logic [1:0]                 ILA_CS_O,
	input wire logic                       MF_BOUNDARY_O,
	// link control
	input wire logic                       LINK_RESET_N_O,
	input wire logic                       SERDES_POWER_DOWN_O,
	input wire logic                       LINK_CLK_ENABLE_O,
	input wire logic                       LINK_IS_64B_O,
	input wire logic [5:0]                 LINK_OUTPUT_MODE_O
);
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (!RST_N_I);

	sequence s_req;
		CYC_I && STB_I && !ACK_O;
	endsequence
	sequence s_ack_pulse;
		ACK_O ##1 !ACK_O;
	endsequence

	a_ack_answer: assert property (s_req |=> s_ack_pulse)
		else $error("ack missing or longer than one cycle");
	a_ack_cause: assert property ($rose(ACK_O) |-> $past(CYC_I && STB_I))
		else $error("ack without request");
	a_ila_cs_zero: assert property (ILA_CS_O == 2'h0)
		else $error("lane alignment reports control bits");
	a_disabled_off: assert property (!LINK_RESET_N_O |->
		SERDES_POWER_DOWN_O && !LINK_CLK_ENABLE_O)
		else $error("disabled link not powered down and gated");
	a_no_boundary: assert property (!LINK_RESET_N_O |-> !MF_BOUNDARY_O)
		else $error("boundary pulse while link disabled");
	a_zero_samples: assert property (!LINK_CLK_ENABLE_O |-> SAMPLE_O == '0)
		else $error("samples while link disabled");
	a_mode_64b: assert property (LINK_IS_64B_O ==
		($past(LINK_OUTPUT_MODE_O) >= FIRST_64B_MODE))
		else $error("link layer flag disagrees with mode");
	a_sample_field: assert property (LINK_CLK_ENABLE_O &&
		$past(LINK_CLK_ENABLE_O, 3) |-> SAMPLE_O[3:1] == 3'h0 &&
		SAMPLE_O[N_BITS-1:N_BITS-RES] == $past(ADC_SAMPLE_I[RES-1:0], 3))
		else $error("converter data misplaced in sample field");
endmodule : link_ctrl_chk

bind serial_link_control_regs link_ctrl_chk #(
	.CHANNELS(CHANNELS),
	.RES(RES),
	.N_BITS(N_BITS),
	.FIRST_64B_MODE(FIRST_64B_MODE)
) u_chk (
	.CORE_CLK_I(CORE_CLK_I),
	.RST_N_I(RST_N_I),
	.CYC_I(CYC_I),
	.STB_I(STB_I),
	.ACK_O(ACK_O),
	.ADC_SAMPLE_I(ADC_SAMPLE_I),
	.SAMPLE_O(SAMPLE_O),
	.ILA_CS_O(ILA_CS_O),
	.MF_BOUNDARY_O(MF_BOUNDARY_O),
	.LINK_RESET_N_O(LINK_RESET_N_O),
	.SERDES_POWER_DOWN_O(SERDES_POWER_DOWN_O),
	.LINK_CLK_ENABLE_O(LINK_CLK_ENABLE_O),
	.LINK_IS_64B_O(LINK_IS_64B_O),
	.LINK_OUTPUT_MODE_O(LINK_OUTPUT_MODE_O)
);

// >>> verification/serial_link_control_regs_tb_top.sv
// self-checking bench for the link control bank
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
	failures++; $display("mismatch at %0t: got %h exp %h", $time, got, exp); \
	end end
module serial_link_control_regs_tb_top;
	localparam int E = 1;
	localparam int F = 8;
	logic        clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0;
	logic        we = 1'b0, ts = 1'b0, sysref = 1'b0;
	logic [3:0]  sel = 4'h0;
	logic [11:0] adr = 12'h000;
	logic [31:0] dat = 32'h0, q, dat_o;
	logic [47:0] adc = 48'h0;
	logic [63:0] sample;
	logic [15:0] period, pulses, n;
	logic [5:0]  mode;
	logic        ack, mf, lrst_n, pd, cen, is64, cal, tsr;
	int          failures = 0, comparisons = 0, cycles = 0;

	serial_link_control_regs #(.E_64B(E), .F_64B(F)) u_dut (
		.CORE_CLK_I(clk), .RST_N_I(rst_n), .CYC_I(cyc), .STB_I(stb),
		.WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat), .DAT_O(dat_o),
		.ACK_O(ack), .ADC_SAMPLE_I(adc), .TIMESTAMP_I(ts),
		.SYSREF_I(sysref), .SAMPLE_O(sample), .ILA_CS_O(),
		.MF_BOUNDARY_O(mf), .LINK_RESET_N_O(lrst_n),
		.SERDES_POWER_DOWN_O(pd), .LINK_CLK_ENABLE_O(cen),
		.LINK_IS_64B_O(is64), .LINK_OUTPUT_MODE_O(mode),
		.CAL_ENABLE_O(cal), .TS_RECV_ENABLE_O(tsr));
	link_rx_model u_rx (.clk_i(clk), .rst_n_i(rst_n), .clk_en_i(cen),
		.boundary_i(mf), .period_o(period), .pulses_o(pulses));

	initial forever #12.5 clk = ~clk;
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failures++;
			tally_and_finish();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic wb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
		sel <= 4'hF;
		do @(posedge clk); while (ack !== 1'b1);
		q = dat_o;
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
		sel <= 4'h0;
	endtask : wb
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		`CHK(q, e)
	endtask : rd_chk
	task automatic t_reset_vals;
		rd_chk(12'h580, 32'h00000000);
		rd_chk(12'h800, 32'h00000001);
		rd_chk(12'h804, 32'h00000000);
		rd_chk(12'h808, 32'h0000001F);
		rd_chk(12'hFFC, 32'h00000000);
		wb(1'b0, 12'h844, 32'h0);
		`CHK(q[17:8], 10'h01F)
	endtask : t_reset_vals
	task automatic t_timestamp;
		wb(1'b1, 12'h840, 32'h00000002);
		wb(1'b1, 12'h580, 32'h00000001);
		for (int k = 0; k < 24; k++)
		begin
			@(posedge clk);
			adc <= {4{k[11:0]}};
			ts <= k[0];
			if (k > 6)
			begin
				`CHK(sample[0], sample[4])
				`CHK(sample[48], sample[52])
			end
		end
		wb(1'b1, 12'h580, 32'h00000000);
		ts <= 1'b1;
		repeat (6) @(posedge clk);
		`CHK(sample[0], 1'b0)
	endtask : t_timestamp
	task automatic t_disable;
		wb(1'b1, 12'h800, 32'h00000000);
		repeat (2) @(posedge clk);
		`CHK({lrst_n, pd, cen}, 3'b010)
		`CHK(sample, 64'h0)
		n = pulses;
		repeat (20) @(posedge clk) sysref <= ~sysref;
		repeat (6) @(posedge clk);
		`CHK(pulses, n)
		// legal K, written while link off
		wb(1'b1, 12'h808, 32'h00000007);
		wb(1'b1, 12'h840, 32'h00000003);
		@(posedge clk);
		`CHK({cal, tsr}, 2'b11)
		wb(1'b1, 12'h800, 32'h00000001);
		repeat (40) @(posedge clk);
		`CHK(period, 16'h0008)
	endtask : t_disable
	task automatic t_mode_64b;
		// link off, then calibration off, then mode
		wb(1'b1, 12'h800, 32'h00000000);
		wb(1'b1, 12'h840, 32'h00000002);
		wb(1'b1, 12'h804, 32'h00000020);
		// calibration on again before link enable
		wb(1'b1, 12'h840, 32'h00000003);
		wb(1'b1, 12'h800, 32'h00000001);
		repeat (3) @(posedge clk);
		`CHK(mode, 6'h20)
		`CHK(is64, 1'b1)
		repeat (120) @(posedge clk);
		`CHK(period, 16'(256 * E / F))
		wb(1'b0, 12'h844, 32'h0);
		`CHK(q[17:8], 10'(256 * E / F - 1))
	endtask : t_mode_64b
	task automatic tally_and_finish;
		$display("failures %0d comparisons %0d", failures, comparisons);
		if (failures == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish

	initial
	begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		t_reset_vals();
		t_timestamp();
		t_disable();
		t_mode_64b();
		tally_and_finish();
	end
endmodule : serial_link_control_regs_tb_top
